// [logic/fupc_ctrl.sv]
// Purpose: user program mode controller for on-chip program flash
// Assumes: flash macro reads combinationally while flash_rd_o is high
// Notes: option byte is captured once after reset release
//
// Summary of operation
// - key register resets to zero, user program mode off after reset.
// - mode on only while key equals a5; otherwise no erase, program, lock.
// - control register writes take effect only in user program mode.
// - writing start bit launches selected sector erase or hard lock.
// - byte reads and programs are triggered by table access alone.
// - read-only erase status: 0 after success, 1 after failure.
// - interrupt request during erase aborts it and flags failure.
// - any pending interrupt request stops or refuses user operations.
// - no user operation while the CPU runs from the sub clock.
// - 512 sectors of 128 bytes, bases end in 00 or 80.
// - sector low byte bits 6..0 ignored; bit 7 and high byte select.
// - boot enable 0 refuses table writes and erases in boot area.
// - boot enable 1 makes boot area ordinary program memory.
// - option bits 2..0 size boot area: none, 256 to 2048 from 100.
// - option bits 7..5 choose reset vector 0100, 0200, 0300, 0500, 0900.
// - vector selection and boot size selection are independent.
// - read protection set only in tool mode, never in user mode.
// - tool mode may still erase and program the boot area.
// - sector erase keeps the sector busy for at least 10 ms.
// - opcode 0110 with start bit selects hard lock protection.
// - hard lock refuses every write and erase until a chip erase or a reset.
`timescale 1ns/10ps
`default_nettype none
`include "fupc_params.svh"

module fupc_ctrl #(
  parameter int unsigned ERASE_CYC = `FUPC_ERASE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tbl_rd_i,
  input wire logic tbl_wr_i,
  input wire logic [15:0] tbl_addr_i,
  input wire logic [7:0] tbl_wdata_i,
  output logic [7:0] tbl_rdata_o,
  output logic tbl_rvalid_o,
  output logic tbl_refused_o,
  input wire logic irq_pending_i,
  input wire logic sub_clk_i,
  input wire logic [7:0] opt_byte_i,
  input wire logic tool_mode_i,
  input wire logic tool_rdprot_i,
  input wire logic chip_erase_i,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic flash_rd_o,
  output logic flash_prog_o,
  output logic flash_erase_o,
  input wire logic [7:0] flash_rdata_i,
  output logic busy_o,
  output logic hard_lock_o,
  output logic read_protect_o,
  output logic [15:0] reset_vector_o
);

  // ******************************************************************
  // registers and decode
  // ******************************************************************
  logic [7:0] key_r;
  fupc_pkg::fupc_opc_t opc_r;
  logic estat_r;
  logic [7:0] sech_r;
  logic secl_sel_r;
  logic [7:0] opt_r;
  logic opt_cap_r;
  fupc_pkg::fupc_state_t state_r;
  logic [15:0] sec_base;
  logic upm_en;
  logic wr_ctrl;
  logic erase_req;
  logic lock_req;
  logic prog_req;
  logic erase_ok;
  logic lock_ok;
  logic prog_ok;
  logic abort;
  logic tmr_done;
  logic [`FUPC_TMR_W-1:0] tmr_len;

  // boot area protection check for one address
  function automatic logic boot_prot(input logic [15:0] a, input logic [7:0] opt,
                                     input logic tool);
    logic [15:0] lim;
    lim = `FUPC_BOOT_BASE + (`FUPC_BOOT_UNIT << opt[1:0]);
    boot_prot = !opt[`FUPC_OPT_BOOT_EN] && !opt[`FUPC_OPT_SZ_OFF] && !tool
                && (a >= `FUPC_BOOT_BASE) && (a < lim);
  endfunction

  // key compare and sub clock block
  assign upm_en = (key_r == `FUPC_KEY_OPEN) && !sub_clk_i;
  // only bit 7 of the low byte takes part
  assign sec_base = {sech_r, secl_sel_r, 7'h00};
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `FUPC_OFF_CTRL) && upm_en;
  assign erase_req = wr_ctrl && reg_wdata_i[`FUPC_BIT_START]
                     && (reg_wdata_i[`FUPC_OPC_HI:`FUPC_OPC_LO] == `FUPC_OPC_ERASE)
                     && (state_r == fupc_pkg::FUPC_ST_IDLE);
  assign lock_req = wr_ctrl && reg_wdata_i[`FUPC_BIT_START]
                    && (reg_wdata_i[`FUPC_OPC_HI:`FUPC_OPC_LO] == `FUPC_OPC_LOCK)
                    && (state_r == fupc_pkg::FUPC_ST_IDLE);
  assign prog_req = tbl_wr_i && upm_en && (opc_r == `FUPC_OPC_PROG)
                    && (state_r == fupc_pkg::FUPC_ST_IDLE);
  assign erase_ok = erase_req && !hard_lock_o && !irq_pending_i
                    && !boot_prot(sec_base, opt_r, tool_mode_i);
  assign lock_ok = lock_req && !irq_pending_i;
  assign prog_ok = prog_req && !hard_lock_o && !irq_pending_i
                   && !boot_prot(tbl_addr_i, opt_r, tool_mode_i);
  assign abort = (state_r != fupc_pkg::FUPC_ST_IDLE) && (irq_pending_i || sub_clk_i);
  assign tmr_len = erase_ok ? ERASE_CYC[`FUPC_TMR_W-1:0] : `FUPC_TMR_W'(`FUPC_LOCK_CYC);

  fupc_timer u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(erase_ok || lock_ok),
    .len_i(tmr_len),
    .clr_i(abort),
    .done_o(tmr_done)
  );

  // ******************************************************************
  // software registers
  // ******************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      key_r <= `FUPC_KEY_RST;
    end else if (reg_wr_i && (reg_addr_i == `FUPC_OFF_KEY)) begin
      key_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sech_r <= `FUPC_SEC_RST;
      secl_sel_r <= 1'b0;
    end else if (reg_wr_i && (reg_addr_i == `FUPC_OFF_SECH)) begin
      sech_r <= reg_wdata_i;
    end else if (reg_wr_i && (reg_addr_i == `FUPC_OFF_SECL)) begin
      secl_sel_r <= reg_wdata_i[`FUPC_SECL_SEL];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      opc_r <= `FUPC_OPC_RST;
    end else if (wr_ctrl && (state_r == fupc_pkg::FUPC_ST_IDLE)) begin
      opc_r <= reg_wdata_i[`FUPC_OPC_HI:`FUPC_OPC_LO];
    end
  end

  // ******************************************************************
  // option byte capture
  // ******************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      opt_r <= `FUPC_OPT_RST;
      opt_cap_r <= 1'b0;
    end else if (!opt_cap_r) begin
      opt_r <= opt_byte_i;
      opt_cap_r <= 1'b1;
    end
  end

  // vector from bits 7..5 only, size bits never read here
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reset_vector_o <= `FUPC_VEC_NONE;
    end else if (opt_r[`FUPC_OPT_VEC_OFF]) begin
      reset_vector_o <= `FUPC_VEC_NONE;
    end else begin
      case (opt_r[6:5])
        2'h0: reset_vector_o <= `FUPC_VEC_C0;
        2'h1: reset_vector_o <= `FUPC_VEC_C1;
        2'h2: reset_vector_o <= `FUPC_VEC_C2;
        default: reset_vector_o <= `FUPC_VEC_C3;
      endcase
    end
  end

  // ******************************************************************
  // sequencer
  // ******************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= fupc_pkg::FUPC_ST_IDLE;
    end else begin
      case (state_r)
        fupc_pkg::FUPC_ST_IDLE: begin
          if (erase_ok) begin
            state_r <= fupc_pkg::FUPC_ST_ERASE;
          end else if (lock_ok) begin
            state_r <= fupc_pkg::FUPC_ST_LOCK;
          end
        end
        fupc_pkg::FUPC_ST_ERASE, fupc_pkg::FUPC_ST_LOCK: begin
          if (abort || tmr_done) begin
            state_r <= fupc_pkg::FUPC_ST_IDLE;
          end
        end
        default: state_r <= fupc_pkg::FUPC_ST_IDLE;
      endcase
    end
  end

  // failure is set on erase abort or refused erase start, cleared on clean finish
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      estat_r <= 1'b0;
    end else if (state_r == fupc_pkg::FUPC_ST_ERASE && abort) begin
      estat_r <= 1'b1;
    end else if (erase_req && !erase_ok) begin
      estat_r <= 1'b1;
    end else if (state_r == fupc_pkg::FUPC_ST_ERASE && tmr_done) begin
      estat_r <= 1'b0;
    end
  end

  // chip erase clears, finished lock sets; set wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hard_lock_o <= 1'b0;
    end else if (state_r == fupc_pkg::FUPC_ST_LOCK && tmr_done && !abort) begin
      hard_lock_o <= 1'b1;
    end else if (chip_erase_i) begin
      hard_lock_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      read_protect_o <= 1'b0;
    end else if (tool_mode_i && tool_rdprot_i) begin
      read_protect_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= erase_ok || lock_ok
                || ((state_r != fupc_pkg::FUPC_ST_IDLE) && !abort && !tmr_done);
    end
  end

  // ******************************************************************
  // flash macro drive
  // ******************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flash_erase_o <= 1'b0;
    end else if (erase_ok) begin
      flash_erase_o <= 1'b1;
    end else if (abort || tmr_done) begin
      flash_erase_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flash_addr_o <= 16'h0000;
      flash_wdata_o <= 8'h00;
    end else if (erase_ok) begin
      flash_addr_o <= sec_base;
    end else if (prog_ok) begin
      flash_addr_o <= tbl_addr_i;
      flash_wdata_o <= tbl_wdata_i;
    end else if (tbl_rd_i && (state_r == fupc_pkg::FUPC_ST_IDLE)) begin
      flash_addr_o <= tbl_addr_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flash_prog_o <= 1'b0;
      tbl_refused_o <= 1'b0;
      flash_rd_o <= 1'b0;
    end else begin
      flash_prog_o <= prog_ok;
      tbl_refused_o <= tbl_wr_i && !prog_ok;
      flash_rd_o <= tbl_rd_i && !tbl_wr_i && (state_r == fupc_pkg::FUPC_ST_IDLE);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tbl_rdata_o <= 8'h00;
      tbl_rvalid_o <= 1'b0;
    end else begin
      tbl_rvalid_o <= flash_rd_o;
      tbl_rdata_o <= flash_rd_o ? flash_rdata_i : 8'h00;
    end
  end

  // ******************************************************************
  // register read port
  // ******************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `FUPC_OFF_CTRL: reg_rdata_o <= {opc_r, estat_r, 2'b00,
                                        state_r != fupc_pkg::FUPC_ST_IDLE};
        `FUPC_OFF_KEY: reg_rdata_o <= key_r;
        `FUPC_OFF_SECH: reg_rdata_o <= sech_r;
        `FUPC_OFF_SECL: reg_rdata_o <= {secl_sel_r, 7'h00};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  logic [`FUPC_TMR_W-1:0] erase_age_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i || !flash_erase_o) begin
      erase_age_r <= '0;
    end else begin
      erase_age_r <= erase_age_r + 1'b1;
    end
  end

  property p_key_reset;
    @(posedge mclk_i) $fell(rst_i) |-> (key_r == 8'h00) && !upm_en;
  endproperty
  a_key_reset: assert property (p_key_reset) else $error("key not clear after reset");

  property p_prog_needs_key;
    @(posedge mclk_i) disable iff (rst_i)
      flash_prog_o |-> ($past(key_r) == 8'ha5) && $past(tbl_wr_i);
  endproperty
  a_prog_needs_key: assert property (p_prog_needs_key) else $error("program without key");

  property p_ctrl_gated;
    @(posedge mclk_i) disable iff (rst_i)
      reg_wr_i && (reg_addr_i == 8'h00) && (key_r != 8'ha5) |=> $stable(opc_r)
      && !$rose(flash_erase_o) && !$rose(hard_lock_o);
  endproperty
  a_ctrl_gated: assert property (p_ctrl_gated) else $error("control written while closed");

  property p_erase_start;
    @(posedge mclk_i) disable iff (rst_i)
      erase_ok |=> flash_erase_o && busy_o && (flash_addr_o[6:0] == 7'h00)
      && (flash_addr_o[15:7] == $past({sech_r, secl_sel_r}));
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");

  property p_erase_len;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(flash_erase_o) && !$past(abort) |-> $past(erase_age_r) == ERASE_CYC[16:0] - 1'b1;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

  property p_irq_abort;
    @(posedge mclk_i) disable iff (rst_i)
      flash_erase_o && irq_pending_i |=> !flash_erase_o && estat_r ##1 !busy_o;
  endproperty
  a_irq_abort: assert property (p_irq_abort) else $error("erase not aborted");

  property p_subclk;
    @(posedge mclk_i) disable iff (rst_i)
      sub_clk_i |=> !flash_prog_o && !$rose(flash_erase_o) && !$rose(hard_lock_o);
  endproperty
  a_subclk: assert property (p_subclk) else $error("operation on sub clock");

  property p_boot_refuse;
    @(posedge mclk_i) disable iff (rst_i)
      flash_prog_o |-> !boot_prot(flash_addr_o, opt_r, $past(tool_mode_i));
  endproperty
  a_boot_refuse: assert property (p_boot_refuse) else $error("boot area programmed");

  property p_lock_blocks;
    @(posedge mclk_i) disable iff (rst_i)
      hard_lock_o && !chip_erase_i |=> !flash_prog_o && !$rose(flash_erase_o);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("write under hard lock");

  property p_vec_indep;
    @(posedge mclk_i) disable iff (rst_i)
      opt_cap_r && $stable(opt_r[7:5]) ##1 $stable(opt_r[7:5]) |-> $stable(reset_vector_o);
  endproperty
  a_vec_indep: assert property (p_vec_indep) else $error("vector moved");

endmodule
`default_nettype wire

// [logic/fupc_params.svh]
// Purpose: constants for the flash user program controller
// Assumes: 10 MHz main clock, 8-bit register port
// Notes: offsets are register indices on the plain register port
`ifndef FUPC_PARAMS_SVH
`define FUPC_PARAMS_SVH

// ********************************************************************
// register map and reset values
// ********************************************************************
`define FUPC_OFF_CTRL 8'h00
`define FUPC_OFF_KEY 8'h01
`define FUPC_OFF_SECH 8'h02
`define FUPC_OFF_SECL 8'h03
`define FUPC_KEY_RST 8'h00
`define FUPC_KEY_OPEN 8'ha5
`define FUPC_OPC_RST 4'h0
`define FUPC_SEC_RST 8'h00
`define FUPC_OPT_RST 8'hff

// ********************************************************************
// field layout
// ********************************************************************
`define FUPC_OPC_ERASE 4'ha
`define FUPC_OPC_PROG 4'h5
`define FUPC_OPC_LOCK 4'h6
`define FUPC_BIT_START 0
`define FUPC_BIT_ESTAT 3
`define FUPC_OPC_HI 7
`define FUPC_OPC_LO 4
`define FUPC_SECL_SEL 7
`define FUPC_SEC_LSB 7
`define FUPC_OPT_SZ_OFF 2
`define FUPC_OPT_BOOT_EN 4
`define FUPC_OPT_VEC_OFF 7

// ********************************************************************
// boot area and reset vectors
// ********************************************************************
`define FUPC_BOOT_BASE 16'h0100
`define FUPC_BOOT_UNIT 16'h0100
`define FUPC_VEC_NONE 16'h0100
`define FUPC_VEC_C0 16'h0200
`define FUPC_VEC_C1 16'h0300
`define FUPC_VEC_C2 16'h0500
`define FUPC_VEC_C3 16'h0900

// ********************************************************************
// timing
// ********************************************************************
`define FUPC_ERASE_MS 10
`define FUPC_CLK_KHZ 10000
`define FUPC_ERASE_CYC (`FUPC_ERASE_MS * `FUPC_CLK_KHZ)
`define FUPC_LOCK_CYC 8
`define FUPC_TMR_W 17

`endif

// [logic/fupc_pkg.sv]
// Purpose: types of the flash user program controller
// Assumes: nothing
// Notes: none
`default_nettype none
package fupc_pkg;

  // ******************************************************************
  // sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    FUPC_ST_IDLE  = 3'b001,
    FUPC_ST_ERASE = 3'b010,
    FUPC_ST_LOCK  = 3'b100
  } fupc_state_t;

  typedef logic [3:0] fupc_opc_t;

endpackage
`default_nettype wire

// [logic/fupc_timer.sv]
// Purpose: down counter timing erase and lock operations
// Assumes: load and clear never in the same cycle as a needed done
// Notes: done pulses in the last cycle of the loaded length
`timescale 1ns/10ps
`default_nettype none
`include "fupc_params.svh"

module fupc_timer (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [`FUPC_TMR_W-1:0] len_i,
  input wire logic clr_i,
  output logic done_o
);

  // ******************************************************************
  // counter
  // ******************************************************************
  logic [`FUPC_TMR_W-1:0] cnt_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= len_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done_o = (cnt_r == `FUPC_TMR_W'(1));

endmodule
`default_nettype wire

// [verif/fupc_flash_model.sv]
// Purpose: behavioural program flash macro facing the controller
// Assumes: reads are combinational while the read strobe is high
// Notes: outside a read the data lines toggle so stale bytes never match
`timescale 1ns/10ps
`default_nettype none

module fupc_flash_model (
  input wire logic mclk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic prog_i,
  input wire logic erase_i,
  output logic [7:0] rdata_o,
  output logic [31:0] erase_len_o
);
  // ******************************************************************
  // storage and erase length counter
  // ******************************************************************
  logic [7:0] mem_r [0:65535];
  logic [7:0] idle_r;
  logic erase_d_r;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_r[i] = 8'h00;
    end
    idle_r = 8'h55;
    erase_d_r = 1'b0;
    erase_len_o = 32'h0;
  end

  always @(posedge mclk_i) begin
    idle_r <= ~idle_r;
    erase_d_r <= erase_i;
    if (prog_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    if (erase_i && !erase_d_r) begin
      for (int i = 0; i < 128; i++) begin
        mem_r[{addr_i[15:7], i[6:0]}] <= 8'hff;
      end
      erase_len_o <= 32'h1;
    end else if (erase_i) begin
      erase_len_o <= erase_len_o + 32'h1;
    end
  end

  assign rdata_o = rd_i ? mem_r[addr_i] : idle_r;
endmodule
`default_nettype wire

// [verif/test_fupc_ctrl.sv]
// Purpose: self-checking bench for the flash user program controller
// Assumes: erase shortened to 20 cycles
// Notes: every bus task ends on a rising clock edge
`timescale 1ns/10ps
`default_nettype none
`include "fupc_params.svh"

module test_fupc_ctrl;
  // ******************************************************************
  // signals
  // ******************************************************************
  localparam int ECYC = 20;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i, tbl_rd_i, tbl_wr_i, irq_pending_i, sub_clk_i;
  logic tool_mode_i, tool_rdprot_i, chip_erase_i, tbl_rvalid_o, tbl_refused_o;
  logic flash_rd_o, flash_prog_o, flash_erase_o, busy_o, hard_lock_o, read_protect_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, tbl_wdata_i, tbl_rdata_o, opt_byte_i;
  logic [7:0] flash_wdata_o, flash_rdata_i;
  logic [15:0] tbl_addr_i, flash_addr_o, reset_vector_o;
  logic [31:0] erase_len;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  fupc_ctrl #(.ERASE_CYC(ECYC)) fupc_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tbl_rd_i(tbl_rd_i), .tbl_wr_i(tbl_wr_i),
    .tbl_addr_i(tbl_addr_i), .tbl_wdata_i(tbl_wdata_i), .tbl_rdata_o(tbl_rdata_o),
    .tbl_rvalid_o(tbl_rvalid_o), .tbl_refused_o(tbl_refused_o), .irq_pending_i(irq_pending_i),
    .sub_clk_i(sub_clk_i), .opt_byte_i(opt_byte_i), .tool_mode_i(tool_mode_i),
    .tool_rdprot_i(tool_rdprot_i), .chip_erase_i(chip_erase_i), .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o), .flash_rd_o(flash_rd_o), .flash_prog_o(flash_prog_o),
    .flash_erase_o(flash_erase_o), .flash_rdata_i(flash_rdata_i), .busy_o(busy_o),
    .hard_lock_o(hard_lock_o), .read_protect_o(read_protect_o),
    .reset_vector_o(reset_vector_o));

  fupc_flash_model fupc_flash_model_inst (.mclk_i(mclk_i), .addr_i(flash_addr_o),
    .wdata_i(flash_wdata_o), .rd_i(flash_rd_o), .prog_i(flash_prog_o),
    .erase_i(flash_erase_o), .rdata_o(flash_rdata_i), .erase_len_o(erase_len));

  // ******************************************************************
  // clock, timeout, verdict, compares
  // ******************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run too long", $time);
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // ******************************************************************
  // bus tasks
  // ******************************************************************
  task automatic do_reset(input logic [7:0] opt);
    opt_byte_i <= opt;
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_val(reg_rdata_o, exp, "register read");
    @(posedge mclk_i);
  endtask

  task automatic tbl_wr(input logic [15:0] a, input logic [7:0] d, input logic ok);
    tbl_wr_i <= 1'b1;
    tbl_addr_i <= a;
    tbl_wdata_i <= d;
    @(posedge mclk_i);
    tbl_wr_i <= 1'b0;
    #1;
    chk_flag(flash_prog_o, ok, "program pulse");
    chk_flag(tbl_refused_o, !ok, "refused pulse");
    if (ok) begin
      chk_val(flash_addr_o, a, "program address");
      chk_val(flash_wdata_o, d, "program data");
    end
    @(posedge mclk_i);
  endtask

  task automatic tbl_rd(input logic [15:0] a, input logic [7:0] exp);
    tbl_rd_i <= 1'b1;
    tbl_addr_i <= a;
    @(posedge mclk_i);
    tbl_rd_i <= 1'b0;
    #1;
    chk_flag(flash_rd_o, 1'b1, "macro read");
    @(posedge mclk_i);
    #1;
    chk_flag(tbl_rvalid_o, 1'b1, "read valid");
    chk_val(tbl_rdata_o, exp, "read data");
    @(posedge mclk_i);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 500) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk_flag(busy_o, 1'b0, "sequencer idle");
    @(posedge mclk_i);
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_reset_state;
    reg_chk(`FUPC_OFF_KEY, 8'h00);
    reg_chk(`FUPC_OFF_CTRL, 8'h00);
    chk_val(reset_vector_o, 16'h0100, "vector top bit");
    reg_wr(`FUPC_OFF_CTRL, 8'ha1);
    chk_flag(busy_o, 1'b0, "closed erase");
    reg_chk(`FUPC_OFF_CTRL, 8'h00);
    tbl_wr(16'h1784, 8'h78, 1'b0);
  endtask

  task automatic t_erase;
    reg_wr(`FUPC_OFF_KEY, 8'ha5);
    reg_wr(`FUPC_OFF_SECH, 8'h10);
    reg_wr(`FUPC_OFF_SECL, 8'hff);
    reg_chk(`FUPC_OFF_SECL, 8'h80);
    reg_wr(`FUPC_OFF_CTRL, 8'ha1);
    #1;
    chk_flag(flash_erase_o, 1'b1, "erase running");
    chk_val(flash_addr_o, 16'h1080, "erase base");
    wait_idle();
    chk_val(erase_len[15:0], ECYC[15:0], "erase length");
    reg_chk(`FUPC_OFF_CTRL, 8'ha0);
    tbl_rd(16'h10ff, 8'hff);
    tbl_rd(16'h107f, 8'h00);
  endtask

  task automatic t_abort;
    reg_wr(`FUPC_OFF_CTRL, 8'ha1);
    repeat (5) @(posedge mclk_i);
    irq_pending_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk_flag(flash_erase_o, 1'b0, "erase aborted");
    wait_idle();
    irq_pending_i <= 1'b0;
    reg_chk(`FUPC_OFF_CTRL, 8'ha8);
  endtask

  task automatic t_program;
    reg_wr(`FUPC_OFF_SECH, 8'h17);
    reg_wr(`FUPC_OFF_SECL, 8'h80);
    reg_wr(`FUPC_OFF_CTRL, 8'h51);
    chk_flag(busy_o, 1'b0, "program starts nothing");
    reg_chk(`FUPC_OFF_CTRL, 8'h58);
    tbl_wr(16'h1784, 8'h78, 1'b1);
    tbl_rd(16'h1784, 8'h78);
    irq_pending_i <= 1'b1;
    tbl_wr(16'h1785, 8'h11, 1'b0);
    irq_pending_i <= 1'b0;
    tbl_rd(16'h1785, 8'h00);
    reg_wr(`FUPC_OFF_KEY, 8'h5a);
    reg_chk(`FUPC_OFF_KEY, 8'h5a);
    tbl_wr(16'h1786, 8'h22, 1'b0);
    reg_wr(`FUPC_OFF_KEY, 8'ha5);
    sub_clk_i <= 1'b1;
    reg_wr(`FUPC_OFF_CTRL, 8'ha1);
    chk_flag(busy_o, 1'b0, "sub clock erase");
    reg_chk(`FUPC_OFF_CTRL, 8'h58);
    sub_clk_i <= 1'b0;
  endtask

  task automatic t_lock;
    reg_wr(`FUPC_OFF_CTRL, 8'h61);
    wait_idle();
    chk_flag(hard_lock_o, 1'b1, "lock set");
    reg_wr(`FUPC_OFF_CTRL, 8'h50);
    tbl_wr(16'h0400, 8'h55, 1'b0);
    reg_wr(`FUPC_OFF_CTRL, 8'ha1);
    reg_chk(`FUPC_OFF_CTRL, 8'ha8);
    chip_erase_i <= 1'b1;
    @(posedge mclk_i);
    chip_erase_i <= 1'b0;
    @(posedge mclk_i);
    chk_flag(hard_lock_o, 1'b0, "lock cleared");
    reg_wr(`FUPC_OFF_CTRL, 8'h50);
    tbl_wr(16'h0400, 8'h55, 1'b1);
  endtask

  task automatic t_boot;
    logic [15:0] vec [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
    logic [15:0] top;
    for (int c = 0; c < 4; c++) begin
      do_reset({1'b0, c[1:0], 3'b000, 2'(3 - c)});
      chk_val(reset_vector_o, vec[c], "vector code");
      top = 16'h00ff + (16'h0100 << (3 - c));
      reg_wr(`FUPC_OFF_KEY, 8'ha5);
      reg_wr(`FUPC_OFF_CTRL, 8'h50);
      tbl_wr(top, 8'h33, 1'b0);
      tbl_wr(top + 16'h0001, 8'h33, 1'b1);
    end
    tool_mode_i <= 1'b1;
    tbl_wr(16'h0100, 8'h33, 1'b1);
    tool_mode_i <= 1'b0;
    do_reset(8'h10);
    reg_wr(`FUPC_OFF_KEY, 8'ha5);
    reg_wr(`FUPC_OFF_CTRL, 8'h50);
    tbl_wr(16'h0150, 8'h44, 1'b1);
    do_reset(8'h84);
    chk_val(reset_vector_o, 16'h0100, "vector top bit");
    reg_wr(`FUPC_OFF_KEY, 8'ha5);
    reg_wr(`FUPC_OFF_CTRL, 8'h50);
    tbl_wr(16'h0100, 8'h44, 1'b1);
  endtask

  task automatic t_rdprot;
    tool_rdprot_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_flag(read_protect_o, 1'b0, "protect outside tool");
    tool_mode_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_flag(read_protect_o, 1'b1, "protect in tool");
  endtask

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, tbl_rd_i, tbl_wr_i, irq_pending_i, sub_clk_i} = 7'h00;
    {tool_mode_i, tool_rdprot_i, chip_erase_i} = 3'h0;
    {reg_addr_i, reg_wdata_i, tbl_wdata_i} = 24'h000000;
    tbl_addr_i = 16'h0000;
    opt_byte_i = 8'hff;
    do_reset(8'hff);
    t_reset_state();
    t_erase();
    t_abort();
    t_program();
    t_lock();
    t_boot();
    t_rdprot();
    complete_run();
  end
endmodule
`default_nettype wire
